// ==== shared/cmp_unit_pkg.sv ====
package cmp_unit_pkg;

  // Register byte addresses on the APB slave
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MATCH_LOW = 8'h04;
  localparam logic [7:0] ADDR_MATCH_HIGH = 8'h08;
  localparam logic [7:0] ADDR_EVENT_FLAG = 8'h0C;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_PERIOD = 8'h14;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_TIMER_COUNT = 8'h1C;

  // Control and timer control register field positions
  localparam int CTRL_FMT_BIT = 4;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_CONV_BIT = 8;
  localparam int TCTRL_ON_BIT = 2;

  // Values after reset
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [15:0] MATCH_RESET = 16'h0000;

  // Last values of the 4- and 16-step prescalers and of the four-step time base clock phase
  localparam logic [1:0] PRE4_LAST = 2'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // Period timer input prescale selections
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;

  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    MODE_TOGGLE = 4'h2,
    MODE_CAP_FALL = 4'h4,
    MODE_CAP_RISE = 4'h5,
    MODE_CAP_4TH = 4'h6,
    MODE_CAP_16TH = 4'h7,
    MODE_SET = 4'h8,
    MODE_CLEAR = 4'h9,
    MODE_SOFT = 4'hA,
    MODE_TRIGGER = 4'hB,
    MODE_PWM = 4'hC
  } mode_t;

  typedef struct packed {
    logic en;
    logic conv_sel;
    logic fmt;
    mode_t mode;
  } ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic run;
    logic [1:0] prescale;
    logic [7:0] period;
  } tb_cfg_t;

  typedef struct packed {
    logic [7:0] count;
    logic [9:0] base;
    logic roll;
  } tb_out_t;

endpackage : cmp_unit_pkg

// ==== src/pwm_time_base.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwm_time_base (
  input wire logic clk,
  input wire logic rst_n,
  input wire cmp_unit_pkg::tb_cfg_t cfg,
  output cmp_unit_pkg::tb_out_t tb
);
  import cmp_unit_pkg::*;

  typedef struct packed {
    logic [1:0] phase;
    logic [3:0] pre;
    logic [7:0] count;
    logic roll;
  } tb_state_t;

  tb_state_t s;
  tb_state_t next_s;
  logic tick;
  logic [1:0] frac;

  // Period timer: clock phase feeds the prescaler, prescaler feeds the 8-bit count
  always_comb begin
    next_s = s;
    next_s.roll = 1'b0;
    tick = 1'b0;
    if (cfg.run) begin
      next_s.phase = s.phase + 2'h1;
      if (s.phase == PHASE_LAST) begin
        next_s.pre = s.pre + 4'h1;
        unique case (cfg.prescale)
          PS_DIV1: tick = 1'b1;
          PS_DIV4: tick = (s.pre[1:0] == PRE4_LAST);
          default: tick = (s.pre == PRE16_LAST);
        endcase
      end
      if (tick) begin
        // The increment after a period match restarts the count
        if (s.count == cfg.period) begin
          next_s.count = 8'h00;
          next_s.pre = 4'h0;
          next_s.roll = 1'b1;
        end else begin
          next_s.count = s.count + 8'h01;
        end
      end
    end
  end

  // Two fractional bits: clock phase at 1:1, low two prescaler bits at 1:4, else the top prescaler bits
  always_comb begin
    unique case (cfg.prescale)
      PS_DIV1: frac = s.phase;
      PS_DIV4: frac = s.pre[1:0];
      default: frac = s.pre[3:2];
    endcase
  end

  // One driver for the whole output word
  assign tb = '{count: s.count, base: {s.count, frac}, roll: s.roll};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : pwm_time_base
`default_nettype wire

// ==== src/capture_compare_pwm_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Mode change may set a false flag; software clears the flag afterwards.
// - Event prescaler cleared while disabled, outside capture modes, and on reset.
// - Changing between capture prescale modes keeps the count; software zeroes control first.
// - With instruction clock timing, no captures happen during sleep.
// - With an external timer clock, capture keeps working during sleep.
// - Compare pair matched against reference timer; match toggles, sets or clears output.
// - Every match sets the flag and optionally starts a conversion.
// - Writing zero to control forces the compare output latch low.
// - Trigger mode resets the timer one edge later unless the match was removed.
// - Compare works in sleep only if the reference timer keeps running.
// - Match during sleep with event enable set wakes the device.
// - PWM mode drives the pin with up to ten bits of resolution.
// - PWM time base is the 8-bit period timer plus two low bits.
// - Duty value is taken left or right aligned per the align bit.
// - After period match: timer cleared, pin set unless duty zero, duty buffered.
// - Pin driven low when the time base equals the buffered duty.
// - Capture on falling, rising, every 4th or every 16th rising edge.
// - Capture copies the timer into the pair and sets the flag.
module capture_compare_pwm_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire cmp_unit_pkg::apb_req_t apb_req,
  output cmp_unit_pkg::apb_rsp_t apb_rsp,
  input wire logic capture_in,
  input wire logic [15:0] ref_timer,
  input wire logic ref_ext_clock,
  input wire logic sleep,
  output logic unit_pin,
  output logic conv_start,
  output logic ref_timer_clear,
  output logic wake
);
  import cmp_unit_pkg::*;

  typedef struct packed {
    ctrl_t ctrl;
    logic [15:0] match;
    logic flag;
    logic evt_en;
    logic [7:0] period;
    logic tmr_on;
    logic [1:0] prescale;
    logic [2:0] cap_sync;
    logic [3:0] pre_cnt;
    logic match_prev;
    logic trig_pend;
    logic out_latch;
    logic [9:0] duty_buf;
    logic conv_start;
    logic tmr_clear;
    logic wake;
    apb_rsp_t rsp;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;
  logic [1:0] rst_sync;
  logic rst_n_int;
  tb_cfg_t tb_cfg;
  tb_out_t tb;
  logic setup;
  logic access_wr;
  logic addr_ok;
  logic [31:0] rd_data;
  logic ctrl_zero_wr;
  logic cap_mode;
  logic cmp_mode;
  logic pwm_on;
  logic cap_ok;
  logic rise;
  logic fall;
  logic cap_event;
  logic match_now;
  logic hit;
  logic [9:0] duty;

  // Reset released through two flops so every state flop leaves reset together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync[1];

  pwm_time_base u_time_base (
    .clk(clk),
    .rst_n(rst_n_int),
    .cfg(tb_cfg),
    .tb(tb)
  );

  // Period timer freezes during sleep so the waveform state holds
  assign tb_cfg = '{run: s.tmr_on & ~sleep, prescale: s.prescale, period: s.period};

  // Mode decode
  assign cap_mode = (s.ctrl.mode inside {MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_4TH,
                                         MODE_CAP_16TH});
  assign cmp_mode = s.ctrl.en & (s.ctrl.mode inside {MODE_TOGGLE, MODE_SET, MODE_CLEAR,
                                                     MODE_SOFT, MODE_TRIGGER});
  assign pwm_on = s.ctrl.en & (s.ctrl.mode == MODE_PWM);

  // Edges seen only after the second synchroniser stage
  assign rise = s.cap_sync[1] & ~s.cap_sync[2];
  assign fall = ~s.cap_sync[1] & s.cap_sync[2];
  assign cap_ok = ~sleep | ref_ext_clock;

  // Event selection per capture mode
  always_comb begin
    cap_event = 1'b0;
    if (s.ctrl.en & cap_ok) begin
      case (s.ctrl.mode)
        MODE_CAP_FALL: cap_event = fall;
        MODE_CAP_RISE: cap_event = rise;
        MODE_CAP_4TH: cap_event = rise & (s.pre_cnt[1:0] == PRE4_LAST);
        MODE_CAP_16TH: cap_event = rise & (s.pre_cnt == PRE16_LAST);
        default: cap_event = 1'b0;
      endcase
    end
  end

  // Only the first cycle of equality counts, so a stalled timer fires once
  assign match_now = (ref_timer == s.match);
  assign hit = cmp_mode & match_now & ~s.match_prev;

  // Duty alignment: left uses high byte plus two top bits of the low byte
  assign duty = s.ctrl.fmt ? {s.match[15:8], s.match[7:6]} : s.match[9:0];

  // APB decode; zero wait state, answer registered from the setup cycle
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access_wr = apb_req.psel & apb_req.penable & apb_req.pwrite & s.rsp.pready &
                     ~s.rsp.pslverr;
  assign ctrl_zero_wr = access_wr & (apb_req.paddr == ADDR_CONTROL) &
                        (apb_req.pwdata[8:0] == 9'h000);

  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (apb_req.paddr)
      ADDR_CONTROL: rd_data = {23'h000000, s.ctrl.conv_sel, s.ctrl.en, 1'b0, s.out_latch,
                               s.ctrl.fmt, s.ctrl.mode};
      ADDR_MATCH_LOW: rd_data = {24'h000000, s.match[7:0]};
      ADDR_MATCH_HIGH: rd_data = {24'h000000, s.match[15:8]};
      ADDR_EVENT_FLAG: rd_data = {31'h00000000, s.flag};
      ADDR_EVENT_ENABLE: rd_data = {31'h00000000, s.evt_en};
      ADDR_PERIOD: rd_data = {24'h000000, s.period};
      ADDR_TIMER_CONTROL: rd_data = {29'h00000000, s.tmr_on, s.prescale};
      ADDR_TIMER_COUNT: rd_data = {24'h000000, tb.count};
      default: addr_ok = 1'b0;
    endcase
  end

  // Next state: register writes first, then hardware events so they win, then the zero-control latch clear
  always_comb begin
    next_s = s;
    next_s.conv_start = 1'b0;
    next_s.tmr_clear = 1'b0;
    next_s.wake = 1'b0;
    next_s.trig_pend = 1'b0;
    next_s.rsp.pready = setup;
    next_s.rsp.pslverr = setup & ~addr_ok;
    next_s.rsp.prdata = (setup & ~apb_req.pwrite) ? rd_data : 32'h0000_0000;
    next_s.cap_sync = {s.cap_sync[1:0], capture_in};

    // Register writes
    if (access_wr) begin
      case (apb_req.paddr)
        ADDR_CONTROL: begin
          next_s.ctrl.mode = mode_t'(apb_req.pwdata[3:0]);
          next_s.ctrl.fmt = apb_req.pwdata[CTRL_FMT_BIT];
          next_s.ctrl.en = apb_req.pwdata[CTRL_EN_BIT];
          next_s.ctrl.conv_sel = apb_req.pwdata[CTRL_CONV_BIT];
        end
        ADDR_MATCH_LOW: next_s.match[7:0] = apb_req.pwdata[7:0];
        ADDR_MATCH_HIGH: next_s.match[15:8] = apb_req.pwdata[7:0];
        ADDR_EVENT_FLAG: next_s.flag = s.flag & ~apb_req.pwdata[0];
        ADDR_EVENT_ENABLE: next_s.evt_en = apb_req.pwdata[0];
        ADDR_PERIOD: next_s.period = apb_req.pwdata[7:0];
        ADDR_TIMER_CONTROL: begin
          next_s.prescale = apb_req.pwdata[1:0];
          next_s.tmr_on = apb_req.pwdata[TCTRL_ON_BIT];
        end
        default: next_s.match = s.match;
      endcase
    end

    // Event prescaler: held clear unless enabled in a capture mode; a direct
    // switch between capture modes keeps the count, as software expects
    if (!(s.ctrl.en & cap_mode)) begin
      next_s.pre_cnt = 4'h0;
    end else if (rise & cap_ok) begin
      next_s.pre_cnt = s.pre_cnt + 4'h1;
    end

    // Capture overwrites any unread value; wins over a same-cycle write
    if (cap_event) begin
      next_s.match = ref_timer;
      next_s.flag = 1'b1;
    end

    // Compare actions on the first matching cycle
    next_s.match_prev = cmp_mode & match_now;
    if (hit) begin
      next_s.flag = 1'b1;
      next_s.conv_start = s.ctrl.conv_sel;
      next_s.wake = sleep & s.evt_en;
      case (s.ctrl.mode)
        MODE_TOGGLE: next_s.out_latch = ~s.out_latch;
        MODE_SET: next_s.out_latch = 1'b1;
        MODE_CLEAR: next_s.out_latch = 1'b0;
        MODE_TRIGGER: next_s.trig_pend = 1'b1;
        default: next_s.trig_pend = 1'b0;
      endcase
    end

    // Timer reset follows one edge later, only if the match still stands
    if (s.trig_pend & match_now) begin
      next_s.tmr_clear = 1'b1;
    end

    // PWM: set and reload at period roll, clear at duty match
    if (pwm_on) begin
      if (tb.roll) begin
        next_s.duty_buf = duty;
        next_s.out_latch = (duty != 10'h000);
      end else if (tb.base == s.duty_buf) begin
        next_s.out_latch = 1'b0;
      end
    end

    // A zeroed control register forces the compare latch low, last word
    if (ctrl_zero_wr) begin
      next_s.out_latch = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s <= '0;
      s.match <= MATCH_RESET;
      s.period <= PERIOD_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Every output straight from a state flop
  assign apb_rsp = s.rsp;
  assign unit_pin = s.out_latch;
  assign conv_start = s.conv_start;
  assign ref_timer_clear = s.tmr_clear;
  assign wake = s.wake;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_int);

  property p_prescaler_idle;
    !(s.ctrl.en && cap_mode) |=> (s.pre_cnt == 4'h0);
  endproperty
  a_prescaler_idle: assert property (p_prescaler_idle)
    else $error("Event prescaler not cleared outside capture");

  property p_match_flag;
    hit |=> (s.flag && (conv_start == $past(s.ctrl.conv_sel)));
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("Compare match missed flag or conversion start");

  property p_zero_ctrl;
    ctrl_zero_wr |=> (!unit_pin && !s.ctrl.en);
  endproperty
  a_zero_ctrl: assert property (p_zero_ctrl)
    else $error("Zero control write left output high");

  property p_trig_reset;
    (hit && s.ctrl.mode == MODE_TRIGGER) ##1 match_now |=> ref_timer_clear;
  endproperty
  a_trig_reset: assert property (p_trig_reset)
    else $error("Trigger match did not reset timer");

  property p_trig_cancel;
    (hit && s.ctrl.mode == MODE_TRIGGER) ##1 !match_now |=> !ref_timer_clear;
  endproperty
  a_trig_cancel: assert property (p_trig_cancel)
    else $error("Timer reset despite removed match");

  property p_wake;
    (hit && sleep && s.evt_en) |=> (wake && s.flag);
  endproperty
  a_wake: assert property (p_wake)
    else $error("Match in sleep did not wake");

  property p_pwm_set;
    (pwm_on && tb.roll && duty != 10'h000 && !ctrl_zero_wr) |=>
      (unit_pin && s.duty_buf == $past(duty));
  endproperty
  a_pwm_set: assert property (p_pwm_set)
    else $error("PWM period start did not set pin or reload duty");

  property p_pwm_clear;
    (pwm_on && !tb.roll && tb.base == s.duty_buf) |=> !unit_pin;
  endproperty
  a_pwm_clear: assert property (p_pwm_clear)
    else $error("PWM pin not cleared at duty match");

  property p_capture;
    cap_event |=> (s.match == $past(ref_timer) && s.flag);
  endproperty
  a_capture: assert property (p_capture)
    else $error("Capture did not store timer or set flag");

  property p_toggle;
    (hit && s.ctrl.mode == MODE_TOGGLE && !ctrl_zero_wr) |=> (unit_pin != $past(unit_pin));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("Toggle match did not toggle output");

  c_capture: cover property (cap_event && s.ctrl.mode == MODE_CAP_16TH);
  c_trig_reset: cover property (ref_timer_clear);
  c_pwm_cycle: cover property (pwm_on && tb.roll ##[1:1000] !unit_pin);
  c_wake: cover property (wake);

endmodule : capture_compare_pwm_unit
`default_nettype wire

// ==== bench/ref_timer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ref_timer_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic sleep,
  input wire logic ext_clock,
  input wire logic clear,
  input wire logic load,
  input wire logic [15:0] load_val,
  output logic [15:0] count
);
  logic [1:0] phase;

  // Synchronous counter on the instruction clock, one step per four clocks, 1:1 input prescale
  // Holds in sleep unless it runs from an external clock, so no captures on a frozen count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      count <= 16'h0000;
    end else if (load) begin
      count <= load_val;
    end else if (clear) begin
      phase <= 2'h0;
      count <= 16'h0000;
    end else if (run && (!sleep || ext_clock)) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) count <= count + 16'h0001;
    end
  end
endmodule : ref_timer_model
`default_nettype wire

// ==== bench/capture_compare_pwm_unit_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module capture_compare_pwm_unit_test;
  import cmp_unit_pkg::*;
  logic clk, rst_n, capture_in, sleep, ext_clk, run, load, err, conv_d;
  logic unit_pin, conv_start, ref_timer_clear, wake;
  logic [15:0] ref_timer, load_val, m;
  logic [31:0] seed, rv, lo;
  apb_req_t req;
  apb_rsp_t rsp;
  int fail_count = 0, n_checks = 0, conv_cnt = 0, wake_cnt = 0, clr_cnt = 0;
  int h1, p1, h2, p2;
  logic [31:0] rst_exp [8] = '{0, 0, 0, 0, 0, 32'hFF, 0, 0};
  mode_t cmp_mode [5] = '{MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_SOFT, MODE_TRIGGER};
  logic cmp_pin [5] = '{1, 0, 1, 1, 1};
  mode_t cap_mode [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_4TH, MODE_CAP_16TH};
  int cap_n [4] = '{1, 1, 4, 16};

  capture_compare_pwm_unit u_capture_compare_pwm_unit (
    .clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .capture_in(capture_in),
    .ref_timer(ref_timer), .ref_ext_clock(ext_clk), .sleep(sleep), .unit_pin(unit_pin),
    .conv_start(conv_start), .ref_timer_clear(ref_timer_clear), .wake(wake)
  );

  ref_timer_model u_ref_timer_model (
    .clk(clk), .rst_n(rst_n), .run(run), .sleep(sleep), .ext_clock(ext_clk),
    .clear(ref_timer_clear), .load(load), .load_val(load_val), .count(ref_timer)
  );

  // 100 ns system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Control word with enable and conversion source always on
  function automatic logic [31:0] cv(input mode_t md, input logic fmt);
    cv = 32'h0;
    cv[3:0] = md;
    cv[CTRL_FMT_BIT] = fmt;
    cv[CTRL_EN_BIT] = 1'b1;
    cv[CTRL_CONV_BIT] = 1'b1;
  endfunction : cv

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rv = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : put

  task automatic get(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : get

  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      get(ADDR_EVENT_FLAG);
      n++;
    end while (rv[0] !== 1'b1 && n < 100);
  endtask : wait_flag

  task automatic ld(input logic [15:0] v);
    @(posedge clk);
    load <= 1'b1;
    load_val <= v;
    @(posedge clk);
    load <= 1'b0;
  endtask : ld

  task automatic pulse();
    @(posedge clk);
    capture_in <= 1'b1;
    repeat (3) @(posedge clk);
    capture_in <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // High time and full period of one PWM cycle, in clocks
  task automatic meas(output int h, output int p);
    int n;
    n = 0;
    while (unit_pin !== 1'b0 && n < 500) begin @(posedge clk); n++; end
    while (unit_pin !== 1'b1 && n < 500) begin @(posedge clk); n++; end
    h = 0;
    while (unit_pin === 1'b1 && h < 500) begin @(posedge clk); h++; end
    p = h;
    while (unit_pin === 1'b0 && p < 500) begin @(posedge clk); p++; end
  endtask : meas

  // Counts one-cycle pulses; the timer reset must trail the conversion start by one cycle
  always @(posedge clk) begin
    conv_d <= conv_start;
    if (conv_start === 1'b1) conv_cnt++;
    if (wake === 1'b1) wake_cnt++;
    if (ref_timer_clear === 1'b1) begin
      clr_cnt++;
      chk("timer_clear", {31'h0, conv_d}, 32'h1);
    end
  end

  // Cuts a hang short; the whole run needs far fewer cycles
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("mismatch watchdog expected done seen timeout");
    report_and_stop();
  end

  initial begin
    req = '0;
    {capture_in, sleep, ext_clk, run, load} = 5'h00;
    load_val = 16'h0000;
    seed = 32'h96E25A61;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rst_exp[i]) begin
      get(8'(4 * i));
      chk("reset_value", rv, rst_exp[i]);
    end
    get(8'h20);
    chk("unmapped", {31'h0, err}, 32'h1);
    $display("test registers done");
    run <= 1'b1;
    put(ADDR_EVENT_ENABLE, 32'h1);
    foreach (cmp_mode[i]) begin
      seed = lfsr(seed);
      m = seed[15:0] | 16'h0010;
      sleep <= (i == 3);
      ext_clk <= (i == 3);
      // Timer parked below the new match first, so no half-written pair can match
      ld(m - 16'h0008);
      put(ADDR_MATCH_LOW, {24'h0, m[7:0]});
      put(ADDR_MATCH_HIGH, {24'h0, m[15:8]});
      put(ADDR_CONTROL, cv(cmp_mode[i], 1'b0));
      put(ADDR_EVENT_FLAG, 32'h1);
      wait_flag();
      chk("match_flag", rv, 32'h1);
      chk("match_pin", {31'h0, unit_pin}, {31'h0, cmp_pin[i]});
    end
    sleep <= 1'b0;
    ext_clk <= 1'b0;
    chk("conv_count", conv_cnt, 5);
    chk("wake_count", wake_cnt, 1);
    chk("timer_clear_count", clr_cnt, 1);
    put(ADDR_CONTROL, 32'h0);
    repeat (2) @(posedge clk);
    chk("latch_cleared", {31'h0, unit_pin}, 32'h0);
    $display("test compare done");
    run <= 1'b0;
    foreach (cap_mode[i]) begin
      put(ADDR_CONTROL, cv(cap_mode[i], 1'b0));
      if (cap_n[i] > 1) repeat (2) pulse();
      put(ADDR_CONTROL, 32'h0);
      put(ADDR_CONTROL, cv(cap_mode[i], 1'b0));
      seed = lfsr(seed);
      ld(seed[15:0]);
      put(ADDR_EVENT_FLAG, 32'h1);
      repeat (cap_n[i] - 1) pulse();
      get(ADDR_EVENT_FLAG);
      chk("early_capture", rv, 32'h0);
      pulse();
      wait_flag();
      chk("capture_flag", rv, 32'h1);
      get(ADDR_MATCH_LOW);
      lo = rv;
      get(ADDR_MATCH_HIGH);
      chk("capture_value", {rv[23:0], lo[7:0]}, {16'h0, seed[15:0]});
    end
    $display("test capture done");
    put(ADDR_CONTROL, 32'h0);
    put(ADDR_PERIOD, 32'h3);
    put(ADDR_TIMER_CONTROL, 32'h4);
    put(ADDR_MATCH_LOW, 32'h5);
    put(ADDR_MATCH_HIGH, 32'h0);
    put(ADDR_CONTROL, cv(MODE_PWM, 1'b0));
    meas(h1, p1);
    meas(h1, p1);
    put(ADDR_MATCH_LOW, 32'h40);
    put(ADDR_MATCH_HIGH, 32'h2);
    put(ADDR_CONTROL, cv(MODE_PWM, 1'b1));
    meas(h2, p2);
    meas(h2, p2);
    chk("pwm_period", p1, 16);
    chk("pwm_period_left", p2, 16);
    chk("pwm_duty_step", h2 - h1, 4);
    put(ADDR_MATCH_HIGH, 32'h0);
    put(ADDR_MATCH_LOW, 32'h0);
    repeat (32) @(posedge clk);
    h1 = 0;
    repeat (40) begin
      @(posedge clk);
      if (unit_pin !== 1'b0) h1++;
    end
    chk("zero_duty", h1, 0);
    put(ADDR_MATCH_LOW, 32'h40);
    put(ADDR_MATCH_HIGH, 32'h2);
    // Slower period timer: each time-base step lasts four, then sixteen clocks
    for (int k = 1; k < 3; k++) begin
      put(ADDR_TIMER_CONTROL, 32'h4 + 32'(k));
      meas(h1, p1);
      meas(h1, p1);
      chk("pwm_period_scaled", p1, 16 << (2 * k));
      chk("pwm_high_scaled", h1, 9 << (2 * k));
    end
    $display("test pwm done");
    report_and_stop();
  end
endmodule : capture_compare_pwm_unit_test
`default_nettype wire
